//--- include/updown_regs.svh
`ifndef UPDOWN_REGS_SVH
`define UPDOWN_REGS_SVH
`define FREQ_W 16
`define FREQ_RESET 16'h0000
`define CODE_W 11
`define CODE_POLARITY_OFFSET 11'h3e8
`define SRC_UPDOWN 4'h7
`define MODE_CLEAR 1'b0
`define MODE_RETAIN 1'b1
`define OC_RUN 7'h00
`define OC_FAR 7'h01
`define OC_FDT 7'h02
`define OC_LU 7'h03
`define OC_TORQ 7'h04
`define OC_IOL 7'h05
`define OC_IPF 7'h06
`define OC_OL 7'h07
`define OC_RDY 7'h0a
`define OC_FAR2 7'h15
`define OC_IOL2 7'h16
`define OC_TRY 7'h1a
`define OC_OH 7'h1c
`define OC_LIFE 7'h1e
`define OC_REFOFF 7'h21
`define OC_RUN2 7'h23
`define OC_OLP 7'h24
`define OC_ID 7'h25
`define OC_ID2 7'h26
`define OC_PIDALM 7'h2a
`define OC_SECOND_MOTOR_FLAG 7'h31
`define OC_BRAKE_COMMAND_OUT 7'h39
`define OC_RSV_LO 7'h50
`define OC_RSV_HI 7'h52
`define OC_ALM 7'h63
`define FSTOP_ALARM_CODE 8'h08
`endif

//--- include/updown_pkg.sv
package updown_pkg;
    `include "updown_regs.svh"
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DECEL = 2'b10,
        ST_ALARM = 2'b11
    } drive_state_e;
    typedef enum logic [1:0] {
        SRC_OTHER = 2'b00,
        SRC_PID = 2'b01,
        SRC_MULTI = 2'b10,
        SRC_LINK = 2'b11
    } prior_src_e;
    typedef struct packed {
        logic running;
        logic freq_arrival_flag;
        logic freq_detect_flag;
        logic undervoltage_flag;
        logic torque_braking;
        logic output_limiting_flag;
        logic restart_after_dip;
        logic overload_warn;
        logic ready;
        logic freq_arrival2;
        logic output_limiting_delayed;
        logic auto_resetting;
        logic heatsink_warn;
        logic service_life;
        logic reference_loss;
        logic output_on;
        logic overload_prevent;
        logic current_detect;
        logic current_detect2;
        logic pid_alarm;
        logic second_motor_flag;
        logic brake_command_out;
    } status_s;
    typedef struct packed {
        logic [`CODE_W-1:0] out_select_transistor_a;
        logic [`CODE_W-1:0] out_select_transistor_b;
        logic [`CODE_W-1:0] out_select_relay;
    } out_cfg_s;
endpackage : updown_pkg

//--- src/updown_freq_and_terminal_io.sv
// Functional notes
// - Up and down both off or both on: hold output frequency.
// - Up alone: raise frequency at selected acceleration rate.
// - Down alone: lower frequency at selected deceleration rate.
// - Up/down stepping clamps between zero and maximum frequency.
// - Mode 0: each run start and power-on start from zero.
// - Mode 1: last up/down frequency retained and reapplied at restart.
// - Up/down during restart ramp overwrites retained value with present frequency.
// - Selector/PID switch uses prior reference; multistep/link in mode 1 resume retained.
// - Link enable gives link commands priority; unassigned acts as active.
// - Idle speed search input decides catch-spinning-motor at start.
// - Forced stop off: decelerate with its time, then alarm with its code.
// - Forward input drives forward; release decelerates to stop.
// - Reverse input drives reverse; release decelerates to stop.
// - Run functions assignable only through the two run-terminal slots.
// - Output code selects signal; plus 1000 selects active-low; default active-high.
// - Relay energizes on alarm in normal logic, de-energizes in negative.
// - Negative logic outputs appear active while the device is unpowered.
// - Codes map to running, arrival, detect, undervoltage, limiting, ready, etc.
// - Codes 80 to 82 and active-low versions are reserved.
// - Any-alarm output active whenever a protective function trips.
`timescale 1ns/1ps
module updown_freq_and_terminal_io (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic up_cmd_pin,
    input wire logic down_cmd_pin,
    input wire logic freq_source_selector,
    input wire logic pid_cancel_input,
    input wire logic [3:0] multistep_select_pin,
    input wire logic comm_link_enable,
    input wire logic comm_link_enable_assigned,
    input wire logic idle_speed_search,
    input wire logic forced_stop_n,
    input wire logic run_terminal_slot_a_pin,
    input wire logic run_terminal_slot_b_pin,
    input wire logic [6:0] run_terminal_slot_a,
    input wire logic [6:0] run_terminal_slot_b,
    input wire logic [3:0] freq_source_first,
    input wire logic [3:0] freq_source_second,
    input wire logic updown_initial_mode,
    input wire logic [`FREQ_W-1:0] max_freq,
    input wire logic [`FREQ_W-1:0] accel_step,
    input wire logic [`FREQ_W-1:0] decel_step,
    input wire logic [`FREQ_W-1:0] forced_stop_decel_time,
    input wire logic [`FREQ_W-1:0] other_source_freq,
    input wire logic [`FREQ_W-1:0] link_freq,
    input wire logic link_run_fwd,
    input wire logic link_run_rev,
    input wire logic protective_trip,
    input wire logic cfg_load,
    input wire updown_pkg::out_cfg_s out_cfg,
    input wire updown_pkg::status_s status,
    output logic [`FREQ_W-1:0] output_freq,
    output logic [`FREQ_W-1:0] ref_freq,
    output logic run_fwd,
    output logic run_rev,
    output logic start_speed_search,
    output logic link_priority,
    output logic any_alarm_flag,
    output logic [7:0] alarm_code,
    output logic transistor_out_a,
    output logic transistor_out_b,
    output logic relay_energize
);
    import updown_pkg::*;

    // Two-flop synchronisers on every pin input
    localparam int NP = 11;
    logic [NP-1:0] pin_raw, pin_s1, pin_s2;
    assign pin_raw = {up_cmd_pin, down_cmd_pin, freq_source_selector, pid_cancel_input,
                      multistep_select_pin, comm_link_enable, forced_stop_n, idle_speed_search};
    logic [1:0] run_s1, run_s2;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            run_s1 <= '0;
            run_s2 <= '0;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            run_s1 <= {run_terminal_slot_a_pin, run_terminal_slot_b_pin};
            run_s2 <= run_s1;
        end
    end
    wire up_s = pin_s2[10];
    wire dn_s = pin_s2[9];
    wire sel2_s = pin_s2[8];
    wire pidc_s = pin_s2[7];
    wire multi_s = |pin_s2[6:3];
    wire le_s = pin_s2[2];
    wire fstop_n_s = pin_s2[1];
    wire stm_s = pin_s2[0];

    // Run functions exist only on the two dedicated slots (codes 98/99)
    wire fwd_in = (run_terminal_slot_a == 7'd98 && run_s2[1]) ||
                  (run_terminal_slot_b == 7'd98 && run_s2[0]);
    wire rev_in = (run_terminal_slot_a == 7'd99 && run_s2[1]) ||
                  (run_terminal_slot_b == 7'd99 && run_s2[0]);

    wire link_active = le_s || !comm_link_enable_assigned;
    wire cmd_fwd = link_active ? link_run_fwd : fwd_in;
    wire cmd_rev = link_active ? link_run_rev : rev_in;
    wire run_cmd = cmd_fwd ^ cmd_rev;

    // Up/down enabled only when the active source selector is 7
    wire [3:0] act_src = sel2_s ? freq_source_second : freq_source_first;
    wire ud_sel = (act_src == `SRC_UPDOWN) && !link_active && !multi_s && !pidc_s;
    wire inc = up_s && !dn_s;
    wire dec = dn_s && !up_s;

    // Prior source tracking for initial value on switch into up/down
    prior_src_e prior_src;
    wire prior_src_e next_prior = prior_src_e'(link_active ? SRC_LINK : multi_s ? SRC_MULTI :
                                  pidc_s ? SRC_PID : SRC_OTHER);
    logic ud_sel_d;
    logic [`FREQ_W-1:0] retained;
    logic restarting;
    wire entering = ud_sel && !ud_sel_d;
    wire resume_retained = updown_initial_mode == `MODE_RETAIN &&
                           (prior_src == SRC_MULTI || prior_src == SRC_LINK);
    // Entry keeps the outgoing source's reference unless mode 1 resumes the stored one
    wire [`FREQ_W-1:0] entry_ref = resume_retained ? retained : ref_freq;

    // Saturating up/down steps
    wire [`FREQ_W:0] up_sum = {1'b0, ref_freq} + {1'b0, accel_step};
    wire [`FREQ_W-1:0] up_ref = (up_sum > {1'b0, max_freq}) ? max_freq : up_sum[`FREQ_W-1:0];
    wire [`FREQ_W-1:0] dn_ref = (ref_freq > decel_step) ? ref_freq - decel_step : `FREQ_RESET;

    drive_state_e state;
    wire start = (state == ST_IDLE) && run_cmd;
    wire early_cmd = restarting && (inc || dec) && output_freq < ref_freq;

    logic [`FREQ_W-1:0] next_ref;
    always_comb begin
        next_ref = ref_freq;
        if (!ud_sel) begin
            next_ref = link_active ? link_freq : other_source_freq;
        end else if (entering) begin
            next_ref = entry_ref;
        end else if (start) begin
            next_ref = (updown_initial_mode == `MODE_RETAIN) ? retained : `FREQ_RESET;
        end else if (early_cmd) begin
            next_ref = output_freq;
        end else if (state == ST_RUN && inc) begin
            next_ref = up_ref;
        end else if (state == ST_RUN && dec) begin
            next_ref = dn_ref;
        end
    end

    // Output frequency ramp and run sequencing
    wire [`FREQ_W-1:0] ramp_dn = (state == ST_DECEL && !fstop_n_s) ? forced_stop_decel_time : decel_step;
    wire [`FREQ_W-1:0] tgt = (state == ST_RUN) ? ref_freq : `FREQ_RESET;
    wire [`FREQ_W:0] of_up = {1'b0, output_freq} + {1'b0, accel_step};
    wire [`FREQ_W-1:0] next_out = (output_freq < tgt) ?
        ((of_up > {1'b0, tgt}) ? tgt : of_up[`FREQ_W-1:0]) :
        (({1'b0, output_freq} > {1'b0, tgt} + {1'b0, ramp_dn}) ? output_freq - ramp_dn : tgt);
    wire trip = protective_trip;

    drive_state_e next_state;
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: if (trip) next_state = ST_ALARM; else if (run_cmd && fstop_n_s) next_state = ST_RUN;
            ST_RUN: if (trip) next_state = ST_ALARM; else if (!run_cmd || !fstop_n_s) next_state = ST_DECEL;
            ST_DECEL: begin
                if (trip) begin
                    next_state = ST_ALARM;
                end else if (output_freq == `FREQ_RESET) begin
                    next_state = fstop_n_s ? ST_IDLE : ST_ALARM;
                end else if (run_cmd && fstop_n_s) begin
                    next_state = ST_RUN;
                end
            end
            ST_ALARM: next_state = ST_ALARM;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            ref_freq <= `FREQ_RESET;
            output_freq <= `FREQ_RESET;
            prior_src <= SRC_OTHER;
            ud_sel_d <= 1'b0;
            restarting <= 1'b0;
        end else begin
            state <= next_state;
            ref_freq <= next_ref;
            output_freq <= (state == ST_ALARM) ? `FREQ_RESET : next_out;
            prior_src <= next_prior;
            ud_sel_d <= ud_sel;
            restarting <= (start && updown_initial_mode == `MODE_RETAIN) ||
                          (restarting && !early_cmd && output_freq < ref_freq && state != ST_IDLE);
        end
    end

    // Retained value models non-volatile storage: not cleared by reset
    always_ff @(posedge clk) begin
        if (ud_sel && state == ST_RUN && !restarting) begin
            retained <= ref_freq;
        end else if (early_cmd) begin
            retained <= output_freq;
        end
    end

    // Drive-side outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            run_fwd <= 1'b0;
            run_rev <= 1'b0;
            start_speed_search <= 1'b0;
            link_priority <= 1'b0;
            any_alarm_flag <= 1'b0;
            alarm_code <= 8'h00;
        end else begin
            run_fwd <= (state == ST_RUN) && cmd_fwd && !cmd_rev;
            run_rev <= (state == ST_RUN) && cmd_rev && !cmd_fwd;
            start_speed_search <= start ? stm_s : (start_speed_search && state != ST_IDLE);
            link_priority <= link_active;
            any_alarm_flag <= (next_state == ST_ALARM);
            if (state == ST_DECEL && next_state == ST_ALARM && !trip) begin
                alarm_code <= `FSTOP_ALARM_CODE;
            end
        end
    end

    // Output terminal selection
    out_cfg_s cfg;
    logic [2:0] out_q;
    wire [`CODE_W-1:0] code_w [3];
    assign code_w[0] = cfg.out_select_transistor_a;
    assign code_w[1] = cfg.out_select_transistor_b;
    assign code_w[2] = cfg.out_select_relay;
    logic [2:0] sel_sig;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_out
            wire neg = code_w[g] >= `CODE_POLARITY_OFFSET;
            wire [`CODE_W-1:0] base11 = neg ? code_w[g] - `CODE_POLARITY_OFFSET : code_w[g];
            wire [6:0] base = base11[6:0];
            wire rsv = base >= `OC_RSV_LO && base <= `OC_RSV_HI;
            // Codes beyond the table select nothing instead of aliasing a low code
            wire in_range = base11[`CODE_W-1:7] == 4'h0;
            always_comb begin
                case (base)
                    `OC_RUN: sel_sig[g] = status.running;
                    `OC_FAR: sel_sig[g] = status.freq_arrival_flag;
                    `OC_FDT: sel_sig[g] = status.freq_detect_flag;
                    `OC_LU: sel_sig[g] = status.undervoltage_flag;
                    `OC_TORQ: sel_sig[g] = status.torque_braking;
                    `OC_IOL: sel_sig[g] = status.output_limiting_flag;
                    `OC_IPF: sel_sig[g] = status.restart_after_dip;
                    `OC_OL: sel_sig[g] = status.overload_warn;
                    `OC_RDY: sel_sig[g] = status.ready;
                    `OC_FAR2: sel_sig[g] = status.freq_arrival2;
                    `OC_IOL2: sel_sig[g] = status.output_limiting_delayed;
                    `OC_TRY: sel_sig[g] = status.auto_resetting;
                    `OC_OH: sel_sig[g] = status.heatsink_warn;
                    `OC_LIFE: sel_sig[g] = status.service_life;
                    `OC_REFOFF: sel_sig[g] = status.reference_loss;
                    `OC_RUN2: sel_sig[g] = status.output_on;
                    `OC_OLP: sel_sig[g] = status.overload_prevent;
                    `OC_ID: sel_sig[g] = status.current_detect;
                    `OC_ID2: sel_sig[g] = status.current_detect2;
                    `OC_PIDALM: sel_sig[g] = status.pid_alarm;
                    `OC_SECOND_MOTOR_FLAG: sel_sig[g] = status.second_motor_flag;
                    `OC_BRAKE_COMMAND_OUT: sel_sig[g] = status.brake_command_out;
                    `OC_ALM: sel_sig[g] = any_alarm_flag;
                    default: sel_sig[g] = 1'b0;
                endcase
            end
            // Inactive level under negative logic needs drive, so unpowered reads active
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    out_q[g] <= 1'b0;
                end else begin
                    out_q[g] <= ((rsv || !in_range) ? 1'b0 : sel_sig[g]) ^ neg;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg <= '0;
        end else if (cfg_load) begin
            cfg <= out_cfg;
        end
    end

    assign transistor_out_a = out_q[0];
    assign transistor_out_b = out_q[1];
    assign relay_energize = out_q[2];
endmodule : updown_freq_and_terminal_io

//--- testbench/updown_props.sv
`timescale 1ns/1ps
module updown_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic up_cmd_pin,
    input wire logic down_cmd_pin,
    input wire logic freq_source_selector,
    input wire logic pid_cancel_input,
    input wire logic [3:0] multistep_select_pin,
    input wire logic comm_link_enable,
    input wire logic comm_link_enable_assigned,
    input wire logic [3:0] freq_source_first,
    input wire logic [15:0] max_freq,
    input wire logic [15:0] accel_step,
    input wire logic protective_trip,
    input wire logic cfg_load,
    input wire updown_pkg::out_cfg_s out_cfg,
    input wire updown_pkg::status_s status,
    input wire logic [15:0] ref_freq,
    input wire logic run_fwd,
    input wire logic run_rev,
    input wire logic link_priority,
    input wire logic any_alarm_flag,
    input wire logic transistor_out_a,
    input wire logic transistor_out_b,
    input wire logic relay_energize
);
    import updown_pkg::*;
    localparam logic [6:0] CODES [22] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h0a, 7'h15,
        7'h16, 7'h1a, 7'h1c, 7'h1e, 7'h21, 7'h23, 7'h24, 7'h25, 7'h26, 7'h2a, 7'h31, 7'h39};
    out_cfg_s cfg;
    logic quiet;
    logic [16:0] up_sum;
    logic [15:0] up_exp;
    logic [1:0] ea, eb, er;
    // Returns {checkable, level}; the alarm code is judged by the alarm checks instead
    function automatic logic [1:0] pick(input logic [10:0] c, input status_s s);
        logic p;
        logic [10:0] k;
        logic v;
        p = c >= 11'h3e8;
        k = p ? c - 11'h3e8 : c;
        v = 1'b0;
        for (int i = 0; i < 22; i++) begin
            if (k == {4'h0, CODES[i]}) v = s[21 - i];
        end
        return {k != 11'h063, v ^ p};
    endfunction : pick
    always_ff @(posedge clk) begin
        cfg <= sys_rst ? '0 : cfg_load ? out_cfg : cfg;
        ea <= pick(cfg.out_select_transistor_a, status);
        eb <= pick(cfg.out_select_transistor_b, status);
        er <= pick(cfg.out_select_relay, status);
    end
    // Up/down is the only frequency source and the drive is running
    assign quiet = freq_source_first == 4'h7 && !freq_source_selector && !pid_cancel_input && multistep_select_pin == 4'h0
        && comm_link_enable_assigned && !comm_link_enable && (run_fwd || run_rev) && !any_alarm_flag;
    assign up_sum = {1'b0, ref_freq} + {1'b0, accel_step};
    assign up_exp = up_sum > {1'b0, max_freq} ? max_freq : up_sum[15:0];
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_out_a; !$past(sys_rst) && ea[1] |-> transistor_out_a == ea[0]; endproperty
    a_out_a: assert property (p_out_a) else $error("terminal a level wrong");
    property p_out_b; !$past(sys_rst) && eb[1] |-> transistor_out_b == eb[0]; endproperty
    a_out_b: assert property (p_out_b) else $error("terminal b level wrong");
    property p_relay; !$past(sys_rst) && er[1] |-> relay_energize == er[0]; endproperty
    a_relay: assert property (p_relay) else $error("relay level wrong");
    property p_trip; $rose(protective_trip) |-> ##[1:4] any_alarm_flag; endproperty
    a_trip: assert property (p_trip) else $error("trip gave no alarm");
    property p_sticky; any_alarm_flag |=> any_alarm_flag; endproperty
    a_sticky: assert property (p_sticky) else $error("alarm dropped");
    property p_link; (!comm_link_enable_assigned || comm_link_enable) [*5] |-> link_priority; endproperty
    a_link: assert property (p_link) else $error("link priority missing");
    property p_up; (quiet && up_cmd_pin && !down_cmd_pin) [*5] |=> ref_freq == $past(up_exp); endproperty
    a_up: assert property (p_up) else $error("increase step wrong");
    property p_hold; (quiet && up_cmd_pin == down_cmd_pin) [*5] |=> $stable(ref_freq); endproperty
    a_hold: assert property (p_hold) else $error("reference moved while held");
    c_up: cover property (quiet && up_cmd_pin);
    c_alarm: cover property ($rose(any_alarm_flag));
    c_load: cover property (cfg_load);
endmodule : updown_props
bind updown_freq_and_terminal_io updown_props props_u (.*);

//--- testbench/control_equipment.sv
`timescale 1ns/1ps
module control_equipment #(
    parameter int MASK_CYCLES = 30
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [12:0] cmd,
    output logic [12:0] pins = 13'h0004,
    output logic outputs_valid
);
    int age = 0;
    // Terminal levels change just after an edge and stand until the next request
    always @(posedge clk) begin
        pins <= cmd;
        age <= sys_rst ? 0 : (age < MASK_CYCLES ? age + 1 : age);
    end
    // Drive outputs are not trusted until the power-up settling span has passed
    assign outputs_valid = !sys_rst && age == MASK_CYCLES;
endmodule : control_equipment

//--- testbench/updown_freq_and_terminal_io_bench.sv
`timescale 1ns/1ps
module updown_freq_and_terminal_io_bench;
    import updown_pkg::*;
    localparam int UP = 12, DN = 11, LE = 4, IDLE_SPEED_SEARCH = 3, FS = 2, FA = 1, FB = 0;
    localparam logic [10:0] OUT_CODES [10] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h005, 11'h00a, 11'h031,
        11'h039, 11'h050, 11'h052};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [12:0] cmd = 13'h0004;
    logic [12:0] pins;
    logic valid, up_cmd_pin, down_cmd_pin, freq_source_selector, pid_cancel_input, comm_link_enable;
    logic idle_speed_search, forced_stop_n, run_terminal_slot_a_pin, run_terminal_slot_b_pin;
    logic [3:0] multistep_select_pin;
    logic comm_link_enable_assigned = 1'b1;
    logic [6:0] run_terminal_slot_a = 7'h62;
    logic [6:0] run_terminal_slot_b = 7'h63;
    logic [3:0] freq_source_first = 4'h7;
    logic [3:0] freq_source_second = 4'h0;
    logic updown_initial_mode = 1'b0;
    logic [15:0] max_freq = 16'h0100, accel_step = 16'h0010, decel_step = 16'h0004;
    logic [15:0] forced_stop_decel_time = 16'h0020, other_source_freq = 16'h0050, link_freq = 16'h0030;
    logic link_run_fwd = 1'b0, link_run_rev = 1'b0, protective_trip = 1'b0, cfg_load = 1'b0;
    out_cfg_s out_cfg = '0;
    status_s status = '1;
    logic [15:0] output_freq, ref_freq, r0;
    logic run_fwd, run_rev, start_speed_search, link_priority, any_alarm_flag, relay_energize, seen, e;
    logic transistor_out_a, transistor_out_b;
    logic [7:0] alarm_code;
    int bad_count = 0;
    int checked = 0;
    assign {up_cmd_pin, down_cmd_pin, freq_source_selector, pid_cancel_input, multistep_select_pin, comm_link_enable,
        idle_speed_search, forced_stop_n, run_terminal_slot_a_pin, run_terminal_slot_b_pin} = pins;
    always #25 clk = ~clk;
    control_equipment #(.MASK_CYCLES(30)) partner (.clk(clk), .sys_rst(sys_rst), .cmd(cmd), .pins(pins),
        .outputs_valid(valid));
    updown_freq_and_terminal_io dut (.*);
    task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
        checked++;
        if (seen_v !== exp_v) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    task automatic conclude();
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    initial begin
        step(4000);
        bad_count++;
        conclude();
    end
    initial begin
        step(20);
        sys_rst <= 1'b0;
        step(40);
        check(valid, 1'b1);
        check(transistor_out_a, 1'b1);
        cmd[FA] <= 1'b1;
        cmd[UP] <= 1'b1;
        step(8);
        r0 = ref_freq;
        step(4);
        check(ref_freq, r0 + 16'h0040);
        check(run_fwd, 1'b1);
        cmd[DN] <= 1'b1;
        step(4);
        r0 = ref_freq;
        step(6);
        check(ref_freq, r0);
        cmd[DN] <= 1'b0;
        step(30);
        check(ref_freq, 16'h0100);
        decel_step <= 16'h0008;
        cmd[UP] <= 1'b0;
        cmd[DN] <= 1'b1;
        step(6);
        r0 = ref_freq;
        step(4);
        check(ref_freq, r0 - 16'h0020);
        step(40);
        check(ref_freq, 16'h0000);
        cmd[DN] <= 1'b0;
        cmd[FA] <= 1'b0;
        cmd[FB] <= 1'b1;
        step(8);
        check(run_fwd, 1'b0);
        check(run_rev, 1'b1);
        cmd[FB] <= 1'b0;
        run_terminal_slot_a <= 7'h05;
        cmd[FA] <= 1'b1;
        step(8);
        check(run_fwd, 1'b0);
        run_terminal_slot_a <= 7'h62;
        link_run_fwd <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            updown_initial_mode <= m[0];
            link_freq <= m[0] ? 16'h0030 : 16'h0048;
            cmd[UP] <= 1'b1;
            step(30);
            cmd[UP] <= 1'b0;
            cmd[LE] <= 1'b1;
            step(6);
            check(link_priority, 1'b1);
            check(ref_freq, link_freq);
            cmd[LE] <= 1'b0;
            step(6);
            check(ref_freq, m[0] ? 16'h0100 : link_freq);
        end
        comm_link_enable_assigned <= 1'b0;
        step(6);
        check(link_priority, 1'b1);
        comm_link_enable_assigned <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            for (int j = 0; j < 4; j++) begin
                out_cfg <= '{3{OUT_CODES[i] + (j[0] ? 11'h3e8 : 11'h000)}};
                status <= {22{j[1]}};
                cfg_load <= 1'b1;
                step(1);
                cfg_load <= 1'b0;
                step(3);
                e = (i < 8 && j[1]) ^ j[0];
                check(transistor_out_a, e);
                check(transistor_out_b, e);
                check(relay_energize, e);
            end
        end
        updown_initial_mode <= 1'b0;
        cmd[FA] <= 1'b0;
        step(40);
        cmd[IDLE_SPEED_SEARCH] <= 1'b1;
        cmd[FA] <= 1'b1;
        seen = 1'b0;
        repeat (10) begin
            step(1);
            seen |= start_speed_search;
        end
        check(seen, 1'b1);
        check(ref_freq, 16'h0000);
        max_freq <= 16'h0080;
        cmd[UP] <= 1'b1;
        step(20);
        check(ref_freq, 16'h0080);
        cmd[UP] <= 1'b0;
        cmd[FA] <= 1'b0;
        updown_initial_mode <= 1'b1;
        step(30);
        cmd[FA] <= 1'b1;
        step(6);
        check(ref_freq, 16'h0080);
        cmd[UP] <= 1'b1;
        step(5);
        check(ref_freq, 16'h0050);
        cmd[UP] <= 1'b0;
        cmd[FS] <= 1'b0;
        step(100);
        check(output_freq, 16'h0000);
        check(any_alarm_flag, 1'b1);
        check(alarm_code, 8'h08);
        sys_rst <= 1'b1;
        cmd[FS] <= 1'b1;
        step(20);
        sys_rst <= 1'b0;
        out_cfg <= '{11'h000, 11'h000, 11'h063};
        status <= '0;
        cfg_load <= 1'b1;
        step(1);
        cfg_load <= 1'b0;
        step(3);
        check(relay_energize, 1'b0);
        protective_trip <= 1'b1;
        step(6);
        check(any_alarm_flag, 1'b1);
        check(relay_energize, 1'b1);
        out_cfg <= '{11'h000, 11'h000, 11'h44b};
        cfg_load <= 1'b1;
        step(1);
        cfg_load <= 1'b0;
        step(3);
        check(relay_energize, 1'b0);
        conclude();
    end
endmodule : updown_freq_and_terminal_io_bench
